// ===== arcs_pkg.sv
package arcs_pkg;

  // ****************************************************************
  // widths and fixed values
  // ****************************************************************
  localparam int unsigned TIMER_W   = 32;
  localparam int unsigned SHOT_W    = 3;
  localparam logic [2:0]  SHOT_ZERO = 3'h0;
  localparam logic [2:0]  SHOT_ONE  = 3'h1;
  localparam logic [2:0]  SHOT_TWO  = 3'h2;
  localparam logic [2:0]  SHOT_THR  = 3'h3;
  localparam logic [2:0]  SHOT_MAXV = 3'h4;
  localparam logic [31:0] TMR_ONE   = 32'h0000_0001;
  localparam logic [31:0] TMR_ZERO  = 32'h0000_0000;

  // ****************************************************************
  // dead-time path selection
  // ****************************************************************
  typedef enum logic [2:0] {
    DT_SP  = 3'b000,
    DT_3P1 = 3'b001,
    DT_3P2 = 3'b010,
    DT_3P3 = 3'b011,
    DT_3P4 = 3'b100
  } arcs_dt_t;

  // ****************************************************************
  // sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RESET   = 2'b00,
    ST_DEAD    = 2'b01,
    ST_CLOSE   = 2'b10,
    ST_LOCKOUT = 2'b11
  } arcs_state_t;

  // initiate inputs grouped
  typedef struct packed {
    logic single_pole;
    logic three_pole;
    logic three_pole_td;
  } arcs_init_t;

  // dead-time settings in clock cycles
  typedef struct packed {
    logic [31:0] sp;
    logic [31:0] tp1;
    logic [31:0] tp2;
    logic [31:0] tp3;
    logic [31:0] tp4;
  } arcs_dead_cfg_t;

  // per-shot indications
  typedef struct packed {
    logic single_pole_cycle_active;
    logic shot1_three_pole;
    logic shot2_three_pole;
    logic shot3_three_pole;
    logic shot4_three_pole;
  } arcs_shot_ind_t;

endpackage

// ===== arcs_dead_timer.sv
`timescale 1ns/1ns
`default_nettype none
module arcs_dead_timer
  import arcs_pkg::*;
(
  input  wire logic               CLK,       // processing clock
  input  wire logic               NRST,      // async reset, low
  input  wire logic               START,     // load and run
  input  wire logic               STOP,      // abandon timing
  input  wire logic               FREEZE,    // hold count
  input  wire logic [TIMER_W-1:0] PRESET,    // cycles to wait
  output logic                    EXPIRED    // one-cycle pulse
);

  logic [TIMER_W-1:0] cnt_q;
  logic               run_q;
  logic               exp_q;
  wire                last_tick;
  wire  [TIMER_W-1:0] cnt_dec;

  // a zero preset still waits one cycle
  assign last_tick = run_q && !FREEZE && (cnt_q <= TMR_ONE);
  assign cnt_dec   = cnt_q - TMR_ONE;
  assign EXPIRED   = exp_q;

  // ****************************************************************
  // down counter, frozen while held
  // ****************************************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_q <= TMR_ZERO;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      exp_q <= last_tick && !STOP && !START;
      if (STOP) begin
        run_q <= 1'b0;
      end else if (START) begin
        cnt_q <= PRESET;
        run_q <= 1'b1;
      end else if (last_tick) begin
        run_q <= 1'b0;
      end else if (run_q && !FREEZE) begin
        cnt_q <= cnt_dec;
      end
    end
  end

endmodule
`default_nettype wire

// ===== arcs_sequencer.sv
// Contract
// - any initiate below maximum shots, outside lockout, enters in-progress, flag set
// - in-progress clears on close or lockout
// - close only after dead time elapses
// - first shot picks single, three-one, three-two
// - close breaker chosen by sequence setting
// - close latched until closed, reset, lockout
// - shots limited, counter increments per reclose
// - force three-pole while shot count nonzero
// - initiate at maximum shots gives lockout
// - pause freezes all dead timers
// - pause release starts three-pole time two
// - pause forces three-pole trip via time two
// - later shots three-pole, times two to four
// - scheme reset clears shot counter
`timescale 1ns/1ns
`default_nettype none
module arcs_sequencer
  import arcs_pkg::*;
(
  input  wire logic                CLK,                       // 20 MHz clock
  input  wire logic                NRST,                      // async reset, low
  input  wire arcs_init_t          INIT,                      // initiate inputs
  input  wire logic                CYCLE_FREEZE_INPUT,        // pause request
  input  wire logic                BREAKER_OPEN,              // selected breaker open
  input  wire logic                BKR1_CLOSED,               // breaker 1 closed
  input  wire logic                BKR2_CLOSED,               // breaker 2 closed
  input  wire logic                SCHEME_RESET,              // reset from reset logic
  input  wire logic                LOCKOUT_REQ,               // lockout from outside
  input  wire logic                SEQ_SECOND_FIRST,          // 1: breaker 2 first
  input  wire logic                MODE_THREE_POLE_B,         // mode 3 pole b
  input  wire logic [SHOT_W-1:0]   MAX_SHOTS,                 // 1..4
  input  wire arcs_dead_cfg_t      DEAD_CFG,                  // dead times, cycles
  output logic                     RECLOSE_IN_PROGRESS_FLAG,  // in-progress
  output logic                     CLOSE_FIRST_BREAKER_OUT,   // latched close bkr1
  output logic                     CLOSE_SECOND_BREAKER_OUT,  // latched close bkr2
  output logic                     SHOTS_TAKEN_NONZERO,       // count above zero
  output logic                     FORCE_ALL_POLE_TRIP,       // force three pole
  output logic                     LOCKOUT,                   // lockout state
  output logic [SHOT_W-1:0]        SHOT_COUNT,                // shot counter
  output arcs_shot_ind_t           SHOT_IND                   // per-shot flags
);

  // ****************************************************************
  // state and decode
  // ****************************************************************
  arcs_state_t    state_q, state_d;
  arcs_dt_t       dt_sel;
  logic [SHOT_W-1:0] shot_q, shot_d;
  logic           c1_q, c2_q, c1_d, c2_d;
  logic           latched_q;
  logic           tp_latch_q;
  logic           frz_q;
  logic           force_q;
  logic           flag_q, lock_q, nz_q;
  arcs_shot_ind_t ind_q, ind_d;
  logic [TIMER_W-1:0] preset;

  wire any_init     = INIT.single_pole | INIT.three_pole | INIT.three_pole_td;
  wire at_max       = (shot_q >= MAX_SHOTS);
  wire in_rip       = (state_q == ST_DEAD);
  wire pause_fall   = frz_q && !CYCLE_FREEZE_INPUT;
  wire go_lock      = LOCKOUT_REQ || (any_init && at_max && state_q != ST_LOCKOUT);
  wire start_dead   = any_init && !at_max && (state_q == ST_RESET || state_q == ST_CLOSE)
                      && !LOCKOUT_REQ;
  wire restart_dt2  = pause_fall && in_rip;
  wire tmr_start    = start_dead || restart_dt2;
  wire tmr_stop     = go_lock || SCHEME_RESET;
  wire dt_expired;
  wire close_fire   = in_rip && dt_expired && !go_lock && !SCHEME_RESET;
  wire tp_set       = INIT.three_pole || INIT.three_pole_td || CYCLE_FREEZE_INPUT;
  wire tp_clr       = SCHEME_RESET || go_lock;
  wire shot_nz      = (shot_q != SHOT_ZERO);

  // first shot path from fault type and mode, later shots by count
  assign dt_sel = CYCLE_FREEZE_INPUT || pause_fall ? DT_3P2 :
                  (shot_q == SHOT_ONE)  ? DT_3P2 :
                  (shot_q == SHOT_TWO)  ? DT_3P3 :
                  (shot_q == SHOT_THR)  ? DT_3P4 :
                  INIT.three_pole_td    ? DT_3P2 :
                  (INIT.three_pole || MODE_THREE_POLE_B) ? DT_3P1 : DT_SP;

  // preset mux for the shared timer
  assign preset = (dt_sel == DT_SP)  ? DEAD_CFG.sp  :
                  (dt_sel == DT_3P1) ? DEAD_CFG.tp1 :
                  (dt_sel == DT_3P2) ? DEAD_CFG.tp2 :
                  (dt_sel == DT_3P3) ? DEAD_CFG.tp3 : DEAD_CFG.tp4;

  // one timer serves all dead paths, so one freeze holds them all
  arcs_dead_timer u_timer (
    .CLK     (CLK),
    .NRST    (NRST),
    .START   (tmr_start),
    .STOP    (tmr_stop),
    .FREEZE  (CYCLE_FREEZE_INPUT),
    .PRESET  (preset),
    .EXPIRED (dt_expired)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (go_lock) begin
          state_d = ST_LOCKOUT;
        end else if (start_dead) begin
          state_d = ST_DEAD;
        end
      end
      ST_DEAD: begin
        if (go_lock) begin
          state_d = ST_LOCKOUT;
        end else if (SCHEME_RESET) begin
          state_d = ST_RESET;
        end else if (close_fire) begin
          state_d = ST_CLOSE;
        end else if (!BREAKER_OPEN && !latched_q && !any_init) begin
          state_d = ST_RESET;
        end
      end
      ST_CLOSE: begin
        if (go_lock) begin
          state_d = ST_LOCKOUT;
        end else if (SCHEME_RESET) begin
          state_d = ST_RESET;
        end else if (start_dead) begin
          state_d = ST_DEAD;
        end
      end
      ST_LOCKOUT: begin
        if (SCHEME_RESET && !LOCKOUT_REQ) begin
          state_d = ST_RESET;
        end
      end
      default: begin
        state_d = ST_RESET;
      end
    endcase
  end

  // shot counter: clear on reset, bump on each reclose
  always_comb begin
    shot_d = shot_q;
    if (SCHEME_RESET && !go_lock) begin
      shot_d = SHOT_ZERO;
    end else if (close_fire && shot_q < SHOT_MAXV) begin
      shot_d = shot_q + SHOT_ONE;
    end
  end

  // close commands latch until closed, reset or lockout
  always_comb begin
    c1_d = c1_q;
    c2_d = c2_q;
    if (go_lock || SCHEME_RESET) begin
      c1_d = 1'b0;
      c2_d = 1'b0;
    end else begin
      if (close_fire && !SEQ_SECOND_FIRST) begin
        c1_d = 1'b1;
      end else if (BKR1_CLOSED) begin
        c1_d = 1'b0;
      end
      if (close_fire && SEQ_SECOND_FIRST) begin
        c2_d = 1'b1;
      end else if (BKR2_CLOSED) begin
        c2_d = 1'b0;
      end
    end
  end

  // per-shot decode with the single/three-pole latch
  always_comb begin
    ind_d = '0;
    ind_d.single_pole_cycle_active = in_rip && !tp_latch_q && !shot_nz;
    ind_d.shot1_three_pole = in_rip && tp_latch_q && !shot_nz;
    ind_d.shot2_three_pole = in_rip && (shot_q == SHOT_ONE);
    ind_d.shot3_three_pole = in_rip && (shot_q == SHOT_TWO);
    ind_d.shot4_three_pole = in_rip && (shot_q == SHOT_THR);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_RESET;
      shot_q  <= SHOT_ZERO;
      c1_q    <= 1'b0;
      c2_q    <= 1'b0;
      frz_q   <= 1'b0;
      ind_q   <= '0;
      force_q <= 1'b0;
      flag_q  <= 1'b0;
      lock_q  <= 1'b0;
      nz_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      shot_q  <= shot_d;
      c1_q    <= c1_d;
      c2_q    <= c2_d;
      frz_q   <= CYCLE_FREEZE_INPUT;
      ind_q   <= ind_d;
      // force follows the next count so it never lags the shot counter
      force_q <= (shot_d != SHOT_ZERO) || CYCLE_FREEZE_INPUT;
      flag_q  <= (state_d == ST_DEAD);
      lock_q  <= (state_d == ST_LOCKOUT);
      nz_q    <= (shot_d != SHOT_ZERO);
    end
  end

  // latch once breaker opens so a reclosing breaker cannot drop the cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      latched_q <= 1'b0;
    end else if (state_d != ST_DEAD) begin
      latched_q <= 1'b0;
    end else if (BREAKER_OPEN) begin
      latched_q <= 1'b1;
    end
  end

  // reset-dominant three-pole initiation latch
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tp_latch_q <= 1'b0;
    end else if (tp_clr) begin
      tp_latch_q <= 1'b0;
    end else if (tp_set) begin
      tp_latch_q <= 1'b1;
    end
  end

  // outputs straight from flops
  assign RECLOSE_IN_PROGRESS_FLAG = flag_q;
  assign LOCKOUT                  = lock_q;
  assign CLOSE_FIRST_BREAKER_OUT  = c1_q;
  assign CLOSE_SECOND_BREAKER_OUT = c2_q;
  assign SHOT_COUNT               = shot_q;
  assign SHOTS_TAKEN_NONZERO      = nz_q;
  assign FORCE_ALL_POLE_TRIP      = force_q;
  assign SHOT_IND                 = ind_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_init_enters_rip: assert property (@(posedge CLK) disable iff (!NRST)
    start_dead && !SCHEME_RESET |=> RECLOSE_IN_PROGRESS_FLAG)
    else $error("initiate did not enter in-progress");
  a_rip_exit_cause: assert property (@(posedge CLK) disable iff (!NRST)
    RECLOSE_IN_PROGRESS_FLAG && latched_q && !SCHEME_RESET ##1 !RECLOSE_IN_PROGRESS_FLAG
    |-> CLOSE_FIRST_BREAKER_OUT || CLOSE_SECOND_BREAKER_OUT || LOCKOUT)
    else $error("in-progress dropped without close or lockout");
  a_close_needs_dt: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(CLOSE_FIRST_BREAKER_OUT) || $rose(CLOSE_SECOND_BREAKER_OUT)
    |-> $past(dt_expired))
    else $error("close without dead time expiry");
  a_close_select: assert property (@(posedge CLK) disable iff (!NRST)
    close_fire |=> (SEQ_SECOND_FIRST ? CLOSE_SECOND_BREAKER_OUT : CLOSE_FIRST_BREAKER_OUT))
    else $error("wrong breaker closed");
  a_close_hold: assert property (@(posedge CLK) disable iff (!NRST)
    CLOSE_FIRST_BREAKER_OUT && !BKR1_CLOSED && !SCHEME_RESET && !go_lock
    |=> CLOSE_FIRST_BREAKER_OUT)
    else $error("close command dropped early");
  a_shot_inc: assert property (@(posedge CLK) disable iff (!NRST)
    close_fire && !SCHEME_RESET && shot_q < SHOT_MAXV |=> SHOT_COUNT == $past(shot_q) + SHOT_ONE)
    else $error("shot counter did not increment");
  a_force_3p: assert property (@(posedge CLK) disable iff (!NRST)
    SHOT_COUNT != SHOT_ZERO |-> FORCE_ALL_POLE_TRIP && SHOTS_TAKEN_NONZERO)
    else $error("force three pole missing");
  a_lock_holds: assert property (@(posedge CLK) disable iff (!NRST)
    LOCKOUT && !SCHEME_RESET |=> LOCKOUT)
    else $error("lockout left without reset");
  a_first_sp_time: assert property (@(posedge CLK) disable iff (!NRST)
    start_dead && !shot_nz && INIT == 3'b100 && !MODE_THREE_POLE_B && !CYCLE_FREEZE_INPUT
    |-> preset == DEAD_CFG.sp)
    else $error("single-pole first shot used wrong dead time");
  a_later_shot_time: assert property (@(posedge CLK) disable iff (!NRST)
    start_dead && shot_q == SHOT_TWO && !CYCLE_FREEZE_INPUT |-> preset == DEAD_CFG.tp3)
    else $error("third shot used wrong dead time");
  a_resume_time: assert property (@(posedge CLK) disable iff (!NRST)
    restart_dt2 |-> preset == DEAD_CFG.tp2)
    else $error("pause release did not use time two");
  a_max_lockout: assert property (@(posedge CLK) disable iff (!NRST)
    any_init && at_max && !LOCKOUT && !(SCHEME_RESET && !LOCKOUT_REQ) |=> LOCKOUT)
    else $error("initiate at max shots did not lock out");
  a_pause_freeze: assert property (@(posedge CLK) disable iff (!NRST)
    CYCLE_FREEZE_INPUT[*2] |-> !dt_expired)
    else $error("dead timer ran during pause");
  a_reset_clear: assert property (@(posedge CLK) disable iff (!NRST)
    SCHEME_RESET && !go_lock |=> SHOT_COUNT == SHOT_ZERO)
    else $error("reset did not clear shots");
  a_latch_reset_dom: assert property (@(posedge CLK) disable iff (!NRST)
    tp_set && tp_clr |=> !tp_latch_q)
    else $error("three-pole latch set beat reset");

  c_first_close: cover property (@(posedge CLK) disable iff (!NRST)
    $rose(CLOSE_FIRST_BREAKER_OUT));
  c_second_close: cover property (@(posedge CLK) disable iff (!NRST)
    $rose(CLOSE_SECOND_BREAKER_OUT));
  c_lockout: cover property (@(posedge CLK) disable iff (!NRST) $rose(LOCKOUT));
  c_pause_resume: cover property (@(posedge CLK) disable iff (!NRST) restart_dt2);
  c_full_count: cover property (@(posedge CLK) disable iff (!NRST) SHOT_COUNT == SHOT_MAXV);

endmodule
`default_nettype wire

// ===== arcs_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// line side: protection trip and two breakers
// ****************************************************************
module arcs_line_model (
  input  wire logic CLK,     // processing clock
  input  wire logic NRST,    // async reset, low
  input  wire logic TRIP,    // protection trips both breakers
  input  wire logic CLOSE1,  // close command breaker 1
  input  wire logic CLOSE2,  // close command breaker 2
  output logic      OPEN,    // any breaker open
  output logic      B1,      // breaker 1 closed
  output logic      B2       // breaker 2 closed
);
  logic [1:0] lat1_q;
  logic [1:0] lat2_q;
  // mechanism needs three cycles of command, so slow closing is seen
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      B1 <= 1'b1;
      B2 <= 1'b1;
      lat1_q <= 2'h0;
      lat2_q <= 2'h0;
    end else begin
      lat1_q <= CLOSE1 ? lat1_q + 2'h1 : 2'h0;
      lat2_q <= CLOSE2 ? lat2_q + 2'h1 : 2'h0;
      if (TRIP) begin
        B1 <= 1'b0;
        B2 <= 1'b0;
      end else begin
        if (lat1_q == 2'h2) B1 <= 1'b1;
        if (lat2_q == 2'h2) B2 <= 1'b1;
      end
    end
  end
  assign OPEN = ~B1 | ~B2;
endmodule
`default_nettype wire

// ===== autoreclose_cycle_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module autoreclose_cycle_sequencer_tb_top;
  import arcs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  arcs_init_t init = '0;
  logic pause = 1'b0, trip = 1'b0, srst = 1'b0, lreq = 1'b0;
  logic seq2 = 1'b0, mode_b = 1'b0;
  logic [2:0] max_shots = 3'h4;
  arcs_dead_cfg_t dcfg;
  logic opn, b1, b2, flag, cl1, cl2, nz, force3, lock;
  logic [2:0] shots;
  arcs_shot_ind_t ind;
  int n_fail = 0, n_compared = 0, cyc = 0;
  int n;
  // ****************************************************************
  // clock, parts
  // ****************************************************************
  always #25 clk = ~clk;
  assign dcfg = '{32'h6, 32'h9, 32'h4, 32'h7, 32'hB};
  arcs_sequencer uut (.CLK(clk), .NRST(nrst), .INIT(init), .CYCLE_FREEZE_INPUT(pause),
    .BREAKER_OPEN(opn), .BKR1_CLOSED(b1), .BKR2_CLOSED(b2), .SCHEME_RESET(srst),
    .LOCKOUT_REQ(lreq), .SEQ_SECOND_FIRST(seq2), .MODE_THREE_POLE_B(mode_b),
    .MAX_SHOTS(max_shots), .DEAD_CFG(dcfg), .RECLOSE_IN_PROGRESS_FLAG(flag),
    .CLOSE_FIRST_BREAKER_OUT(cl1), .CLOSE_SECOND_BREAKER_OUT(cl2),
    .SHOTS_TAKEN_NONZERO(nz), .FORCE_ALL_POLE_TRIP(force3), .LOCKOUT(lock),
    .SHOT_COUNT(shots), .SHOT_IND(ind));
  arcs_line_model line (.CLK(clk), .NRST(nrst), .TRIP(trip), .CLOSE1(cl1),
    .CLOSE2(cl2), .OPEN(opn), .B1(b1), .B2(b2));
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // present an initiate with a trip; it is taken at the next edge
  task automatic kick(input arcs_init_t iv);
    init = iv;
    trip = 1'b1;
    tick();
    init = '0;
    trip = 1'b0;
  endtask
  // one reclose shot: count cycles from initiate edge to close command
  task automatic shot(input arcs_init_t iv, input int pre, input logic to2, input logic [2:0] cnt);
    kick(iv);
    n = 0;
    while (!(cl1 | cl2) && n < 400) begin
      n++;
      if (n == 1) check(flag, 1'b1);
      if (n == 2) check(ind, cnt == 3'h1 ? ((iv == 3'b100) ? 5'h10 : 5'h08) : (5'h04 >> (cnt - 3'h2)));
      tick();
    end
    n++;
    check(n, pre + 2);
    check({cl2, cl1}, to2 ? 2'h2 : 2'h1);
    check(flag, 1'b0);
    check(shots, cnt);
    repeat (2) tick();
    check({nz, force3}, 2'h3);
    check(cl1 | cl2, 1'b1);
    repeat (3) tick();
    check(cl1 | cl2, 1'b0);
  endtask
  // initiate at the shot limit goes straight to lockout
  task automatic to_lockout;
    kick(3'b010);
    check(lock, 1'b1);
    check(flag, 1'b0);
    repeat (15) tick();
    check(cl1 | cl2, 1'b0);
  endtask
  task automatic do_reset;
    srst = 1'b1;
    tick();
    srst = 1'b0;
    tick();
    check({lock, shots, force3}, 5'h0);
  endtask
  // ****************************************************************
  // hang guard; tests need under 1500 cycles
  // ****************************************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    check({flag, cl1, cl2, lock, shots, force3}, 8'h0);
    // four shots, breaker 2 chosen from the second on
    init = 3'b100;
    tick();
    init = '0;
    tick();
    check(ind.single_pole_cycle_active, 1'b1);
    repeat (8) tick();
    srst = 1'b1;
    tick();
    srst = 1'b0;
    repeat (10) tick();
    shot(3'b100, 6, 1'b0, 3'h1);
    seq2 = 1'b1;
    shot(3'b010, 4, 1'b1, 3'h2);
    shot(3'b010, 7, 1'b1, 3'h3);
    shot(3'b001, 11, 1'b1, 3'h4);
    to_lockout();
    do_reset();
    seq2 = 1'b0;
    // first-shot dead time per initiate and mode, single shot allowed
    max_shots = 3'h1;
    shot(3'b010, 9, 1'b0, 3'h1);
    to_lockout();
    do_reset();
    shot(3'b001, 4, 1'b0, 3'h1);
    to_lockout();
    do_reset();
    mode_b = 1'b1;
    shot(3'b100, 9, 1'b0, 3'h1);
    to_lockout();
    do_reset();
    mode_b = 1'b0;
    // outside lockout cause in mid dead time
    kick(3'b010);
    repeat (3) tick();
    lreq = 1'b1;
    tick();
    lreq = 1'b0;
    tick();
    check({lock, flag}, 2'h2);
    repeat (15) tick();
    check(cl1 | cl2, 1'b0);
    do_reset();
    // pause freezes the timers, release restarts via time two
    kick(3'b010);
    pause = 1'b1;
    repeat (20) tick();
    check({flag, cl1, cl2}, 3'h4);
    check(force3, 1'b1);
    pause = 1'b0;
    n = 0;
    while (!(cl1 | cl2) && n < 40) begin
      n++;
      tick();
    end
    check(n >= 4 && n <= 6, 1'b1);
    repeat (6) tick();
    give_verdict();
  end
endmodule
`default_nettype wire
